// *** rtl/cpr_pkg.sv ***
// constants, types and register map of the commutation phase reference block
// Notes on behaviour
// [R1] V hall edge while U low is hall zero, equal to cycle zero at zero offset.
// [R2] Hall offset is bits 21..16 of hall config, 0..63, 1/64 cycle each.
// [R3] 24-bit phase position register, readable always, writable to force the angle.
// [R4] Hall reference runs at reset if power-on enable set, else on motor-reset command. Hall mode resets off, so the reset reference ends with no hall load.
// [R5] Automatic hall reference never uses the stored phase offset value.
// [R6] In-position flag set only while following error magnitude is below the band.
// [R7] Host homes on index, waits for in-position, then writes stored offset to phase.
// [R8] Commutation angle advanced in motion direction by advance gain times velocity.
// [R9] No velocity phase advance while commutating from hall inputs.
// [R10] Induction: magnetization current along rotor field, torque current perpendicular to it.
// [R11] Induction: field angle advances each update by slip gain times torque command.
// [R12] One slip gain unit is two to the minus 38 cycles per update per count.
// [R13] Phase update rate divided from master clock by straps, default 9.04 kHz.
// [R14] Top bit of hall config selects hall power-on phase referencing.
// [R15] Hall U, V, W are sampled at flag bits 22, 21, 20.
// [R16] Bit 22 of hall config reverses hall direction sense.
// [R17] Each valid hall state maps to a sector angle, plus offset mod 64, into phase.
package cpr_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned PHASE_RATE_HZ = 9040;
  localparam int unsigned UPDATE_DIV = CLK_HZ / PHASE_RATE_HZ;
  // ==========================================
  // register offsets (byte addresses)
  localparam logic [5:0] OFS_HALL_CFG = 6'h00;
  localparam logic [5:0] OFS_CONTROL = 6'h04;
  localparam logic [5:0] OFS_STORED_OFS = 6'h08;
  localparam logic [5:0] OFS_INPOS_BAND = 6'h0C;
  localparam logic [5:0] OFS_PHASE_POS = 6'h10;
  localparam logic [5:0] OFS_ADV_GAIN = 6'h14;
  localparam logic [5:0] OFS_MAG_CUR = 6'h18;
  localparam logic [5:0] OFS_SLIP_GAIN = 6'h1C;
  localparam logic [5:0] OFS_STATUS = 6'h20;
  // ==========================================
  // field positions
  localparam int unsigned CTL_POWER_ON_BIT = 0;
  localparam int unsigned CTL_INDUCTION_BIT = 1;
  localparam int unsigned CTL_MOTOR_RESET_BIT = 2;
  localparam int unsigned ST_INPOS_BIT = 0;
  localparam int unsigned ST_REF_DONE_BIT = 1;
  localparam int unsigned ST_REF_WAIT_BIT = 2;
  localparam int unsigned ST_HALL_FAULT_BIT = 3;
  localparam int unsigned ST_HALL_LSB = 4;
  localparam int unsigned HALL_U_BIT = 22;
  localparam int unsigned HALL_V_BIT = 21;
  localparam int unsigned HALL_W_BIT = 20;
  localparam int unsigned SECTOR_SHIFT = 18;
  localparam int unsigned SLIP_FRAC = 38;
  localparam int unsigned ADV_SHIFT = 8;
  // ==========================================
  // reset values
  localparam logic [23:0] HALL_CFG_RST = 24'h000000;
  localparam logic [1:0] CONTROL_RST = 2'h1;
  localparam logic [23:0] WORD24_RST = 24'h000000;
  localparam logic [15:0] WORD16_RST = 16'h0000;
  // ==========================================
  // hall states (U,V,W) and sector angles in 1/64 cycle
  localparam logic [2:0] HALL_S0 = 3'h3;
  localparam logic [2:0] HALL_S1 = 3'h2;
  localparam logic [2:0] HALL_S2 = 3'h6;
  localparam logic [2:0] HALL_S3 = 3'h4;
  localparam logic [2:0] HALL_S4 = 3'h5;
  localparam logic [2:0] HALL_S5 = 3'h1;
  localparam logic [5:0] SECT_A0 = 6'h00;
  localparam logic [5:0] SECT_A1 = 6'h0B;
  localparam logic [5:0] SECT_A2 = 6'h15;
  localparam logic [5:0] SECT_A3 = 6'h20;
  localparam logic [5:0] SECT_A4 = 6'h2B;
  localparam logic [5:0] SECT_A5 = 6'h35;
  // ==========================================
  // types
  typedef struct packed {
    logic hall_mode;
    logic reverse;
    logic [5:0] offset;
    logic [15:0] address;
  } cpr_hall_cfg_t;
  typedef struct packed {
    logic [23:0] angle;
    logic signed [15:0] iq;
    logic signed [15:0] id;
  } cpr_drive_t;
  typedef enum logic [1:0] {
    REF_IDLE = 2'b00,
    REF_WAIT = 2'b01,
    REF_DONE = 2'b11
  } cpr_ref_state_t;
endpackage : cpr_pkg

// *** rtl/cpr_top.sv ***
// commutation phase reference, phase advance and slip logic with avalon-mm registers
`timescale 1ns/100ps
module cpr_top #(
  parameter int unsigned UPDATE_DIV_P = cpr_pkg::UPDATE_DIV
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // avalon-mm slave
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // pins: flag register bits and straps
  input wire logic [23:0] FLAG_WORD_I,
  input wire logic [1:0] STRAP_DIV_I,
  // servo side, same clock
  input wire logic signed [23:0] FOLLOW_ERR_I,
  input wire logic signed [15:0] VELOCITY_I,
  input wire logic signed [15:0] IQ_CMD_I,
  input wire logic signed [23:0] PHASE_DELTA_I,
  // amplifier side
  output cpr_pkg::cpr_drive_t DRIVE_O,
  output logic PHASE_UPDATE_O,
  output logic IN_POSITION_O
);
  // ==========================================
  // pin synchronisers
  logic [2:0] hall_meta;
  logic [2:0] hall;
  logic [1:0] strap_meta;
  logic [1:0] strap_sync;
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      hall_meta <= 3'h0;
      hall <= 3'h0;
      strap_meta <= 2'h0;
      strap_sync <= 2'h0;
    end else begin
      hall_meta <= {FLAG_WORD_I[cpr_pkg::HALL_U_BIT], FLAG_WORD_I[cpr_pkg::HALL_V_BIT],
                    FLAG_WORD_I[cpr_pkg::HALL_W_BIT]}; // R15
      hall <= hall_meta;
      strap_meta <= STRAP_DIV_I;
      strap_sync <= strap_meta;
    end
  end

  // ==========================================
  // registers
  cpr_pkg::cpr_hall_cfg_t hall_cfg;
  logic [1:0] control;
  logic [23:0] stored_ofs;
  logic [23:0] inpos_band;
  logic [23:0] phase_pos;
  logic signed [15:0] adv_gain;
  logic signed [15:0] mag_cur;
  logic [23:0] slip_gain;
  logic ack;
  logic in_pos;
  logic hall_fault;
  logic upd;
  cpr_pkg::cpr_ref_state_t ref_state;

  wire req = AVS_READ_I | AVS_WRITE_I;
  wire wr_en = AVS_WRITE_I & ack;
  wire wr_hall = wr_en & (AVS_ADDRESS_I == cpr_pkg::OFS_HALL_CFG);
  wire wr_ctl = wr_en & (AVS_ADDRESS_I == cpr_pkg::OFS_CONTROL);
  wire wr_sofs = wr_en & (AVS_ADDRESS_I == cpr_pkg::OFS_STORED_OFS);
  wire wr_band = wr_en & (AVS_ADDRESS_I == cpr_pkg::OFS_INPOS_BAND);
  wire wr_phase = wr_en & (AVS_ADDRESS_I == cpr_pkg::OFS_PHASE_POS);
  wire wr_adv = wr_en & (AVS_ADDRESS_I == cpr_pkg::OFS_ADV_GAIN);
  wire wr_mag = wr_en & (AVS_ADDRESS_I == cpr_pkg::OFS_MAG_CUR);
  wire wr_slip = wr_en & (AVS_ADDRESS_I == cpr_pkg::OFS_SLIP_GAIN);
  wire motor_reset_cmd = wr_ctl & AVS_WRITEDATA_I[cpr_pkg::CTL_MOTOR_RESET_BIT];
  wire power_on_en = control[cpr_pkg::CTL_POWER_ON_BIT];
  wire induction = control[cpr_pkg::CTL_INDUCTION_BIT];
  wire [7:0] status = {1'b0, hall, hall_fault, ref_state == cpr_pkg::REF_WAIT,
                       ref_state == cpr_pkg::REF_DONE, in_pos};

  assign AVS_WAITREQUEST_O = req & ~ack;

  logic [31:0] rd_mux;
  always_comb begin
    unique case (AVS_ADDRESS_I)
      cpr_pkg::OFS_HALL_CFG: rd_mux = {8'h00, hall_cfg};
      cpr_pkg::OFS_CONTROL: rd_mux = {30'h00000000, control};
      cpr_pkg::OFS_STORED_OFS: rd_mux = {8'h00, stored_ofs};
      cpr_pkg::OFS_INPOS_BAND: rd_mux = {8'h00, inpos_band};
      cpr_pkg::OFS_PHASE_POS: rd_mux = {8'h00, phase_pos}; // R3
      cpr_pkg::OFS_ADV_GAIN: rd_mux = {16'h0000, adv_gain};
      cpr_pkg::OFS_MAG_CUR: rd_mux = {16'h0000, mag_cur};
      cpr_pkg::OFS_SLIP_GAIN: rd_mux = {8'h00, slip_gain};
      cpr_pkg::OFS_STATUS: rd_mux = {24'h000000, status};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      ack <= 1'b0;
      AVS_READDATA_O <= 32'h00000000;
    end else begin
      ack <= req & ~ack;
      AVS_READDATA_O <= (AVS_READ_I & ~ack) ? rd_mux : AVS_READDATA_O;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      hall_cfg <= cpr_pkg::HALL_CFG_RST;
      control <= cpr_pkg::CONTROL_RST;
      stored_ofs <= cpr_pkg::WORD24_RST;
      inpos_band <= cpr_pkg::WORD24_RST;
      adv_gain <= cpr_pkg::WORD16_RST;
      mag_cur <= cpr_pkg::WORD16_RST;
      slip_gain <= cpr_pkg::WORD24_RST;
    end else begin
      if (wr_hall) hall_cfg <= AVS_WRITEDATA_I[23:0];
      if (wr_ctl) control <= AVS_WRITEDATA_I[1:0];
      if (wr_sofs) stored_ofs <= AVS_WRITEDATA_I[23:0];
      if (wr_band) inpos_band <= AVS_WRITEDATA_I[23:0];
      if (wr_adv) adv_gain <= AVS_WRITEDATA_I[15:0];
      if (wr_mag) mag_cur <= AVS_WRITEDATA_I[15:0];
      if (wr_slip) slip_gain <= AVS_WRITEDATA_I[23:0];
    end
  end

  // ==========================================
  // phase update divider from straps
  logic [1:0] init_cnt;
  logic [1:0] strap;
  logic [17:0] div_cnt;
  wire [17:0] div_len = 18'(UPDATE_DIV_P) * {16'h0000, strap} + 18'(UPDATE_DIV_P);
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      init_cnt <= 2'h0;
      strap <= 2'h0;
      div_cnt <= 18'h00000;
      upd <= 1'b0;
    end else begin
      init_cnt <= (init_cnt == 2'h3) ? init_cnt : init_cnt + 2'h1;
      if (init_cnt == 2'h2) strap <= strap_sync; // R13
      div_cnt <= (div_cnt + 18'h00001 >= div_len) ? 18'h00000 : div_cnt + 18'h00001; // R13
      upd <= (init_cnt == 2'h3) && (div_cnt + 18'h00001 >= div_len);
    end
  end
  assign PHASE_UPDATE_O = upd;

  // ==========================================
  // hall rough phase reference
  logic [5:0] sector;
  always_comb begin
    hall_fault = 1'b0;
    unique case (hall)
      cpr_pkg::HALL_S0: sector = cpr_pkg::SECT_A0; // R1
      cpr_pkg::HALL_S1: sector = cpr_pkg::SECT_A1;
      cpr_pkg::HALL_S2: sector = cpr_pkg::SECT_A2;
      cpr_pkg::HALL_S3: sector = cpr_pkg::SECT_A3;
      cpr_pkg::HALL_S4: sector = cpr_pkg::SECT_A4;
      cpr_pkg::HALL_S5: sector = cpr_pkg::SECT_A5;
      default: begin
        sector = 6'h00;
        hall_fault = 1'b1;
      end
    endcase
  end
  wire [5:0] sector_dir = hall_cfg.reverse ? 6'h00 - sector : sector; // R16
  wire [5:0] ref_angle = sector_dir + hall_cfg.offset; // R2 R17
  wire ref_load = (ref_state == cpr_pkg::REF_WAIT) & ~hall_fault;

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      ref_state <= cpr_pkg::CONTROL_RST[cpr_pkg::CTL_POWER_ON_BIT] ? cpr_pkg::REF_WAIT : cpr_pkg::REF_IDLE; // R4
    end else begin
      unique case (ref_state)
        cpr_pkg::REF_IDLE: if (motor_reset_cmd) ref_state <= cpr_pkg::REF_WAIT; // R4
        cpr_pkg::REF_WAIT: if (ref_load || !hall_cfg.hall_mode) ref_state <= cpr_pkg::REF_DONE; // R14
        cpr_pkg::REF_DONE: if (motor_reset_cmd) ref_state <= cpr_pkg::REF_WAIT;
        default: ref_state <= cpr_pkg::REF_IDLE;
      endcase
    end
  end
  wire hall_load = ref_load & hall_cfg.hall_mode; // R14

  // ==========================================
  // phase position, advance and slip
  logic [37:0] field_acc;
  wire signed [31:0] adv_prod = adv_gain * VELOCITY_I;
  wire [23:0] adv_term = hall_cfg.hall_mode ? 24'h000000 : adv_prod[cpr_pkg::ADV_SHIFT +: 24]; // R8 R9
  wire signed [40:0] slip_inc = $signed({1'b0, slip_gain}) * IQ_CMD_I; // R12
  wire [23:0] slip_angle = induction ? field_acc[cpr_pkg::SLIP_FRAC - 1 -: 24] : 24'h000000;
  wire [23:0] angle_sum = phase_pos + slip_angle + adv_term;

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      phase_pos <= cpr_pkg::WORD24_RST;
    end else if (hall_load) begin
      phase_pos <= {ref_angle, 18'h00000}; // R5 R17
    end else if (wr_phase) begin
      phase_pos <= AVS_WRITEDATA_I[23:0]; // R3
    end else if (upd) begin
      phase_pos <= phase_pos + PHASE_DELTA_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      field_acc <= 38'h0000000000;
      DRIVE_O <= '0;
    end else if (upd) begin
      field_acc <= induction ? field_acc + slip_inc[37:0] : 38'h0000000000; // R11
      DRIVE_O.angle <= angle_sum;
      DRIVE_O.iq <= IQ_CMD_I; // R10
      DRIVE_O.id <= induction ? mag_cur : 16'h0000; // R10
    end
  end

  // ==========================================
  // in-position flag
  wire [23:0] err_mag = FOLLOW_ERR_I[23] ? 24'h000000 - FOLLOW_ERR_I : FOLLOW_ERR_I;
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      in_pos <= 1'b0;
    end else begin
      in_pos <= err_mag < inpos_band; // R6
    end
  end
  assign IN_POSITION_O = in_pos;

  // ==========================================
  // assertions
  a_hall_zero_point: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R1
    hall_load && hall == cpr_pkg::HALL_S0 && hall_cfg.offset == 6'h00 |=> phase_pos == 24'h000000)
    else $error("hall zero point not at cycle zero");
  a_offset_load: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R2
    hall_load |=> phase_pos[23:18] == $past(sector_dir + hall_cfg.offset))
    else $error("hall offset not added to sector");
  a_stored_unused: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R5
    hall_load |=> phase_pos[17:0] == 18'h00000)
    else $error("hall reference used more than sector and offset");
  a_phase_write: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R3
    wr_phase && !hall_load |=> phase_pos == $past(AVS_WRITEDATA_I[23:0]))
    else $error("phase position write lost");
  a_motor_reset: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R4
    motor_reset_cmd && ref_state != cpr_pkg::REF_WAIT |=> ref_state == cpr_pkg::REF_WAIT)
    else $error("motor reset did not start reference");
  a_in_position: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R6
    IN_POSITION_O |-> $past(err_mag < inpos_band))
    else $error("in-position flag with large error");
  a_no_hall_adv: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R9
    upd && hall_cfg.hall_mode && !induction |=> DRIVE_O.angle == $past(phase_pos))
    else $error("phase advance applied in hall mode");
  a_vel_advance: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R8
    upd && !hall_cfg.hall_mode && !induction |=> DRIVE_O.angle == $past(phase_pos + adv_prod[31:8]))
    else $error("velocity advance wrong");
  a_slip_step: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R11
    upd && induction |=> field_acc == $past(field_acc + slip_inc[37:0]))
    else $error("slip angle step wrong");
  a_mag_current: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R10
    upd |=> DRIVE_O.id == ($past(induction) ? $past(mag_cur) : 16'h0000) && DRIVE_O.iq == $past(IQ_CMD_I))
    else $error("drive currents wrong");
  a_update_gap: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R13
    upd |=> !upd [*8])
    else $error("phase updates too close");
  a_bus_wait: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    req && !ack |-> AVS_WAITREQUEST_O ##1 (!req || !AVS_WAITREQUEST_O))
    else $error("waitrequest answer wrong");
  a_hall_sync: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R15
    1'b1 |-> hall == $past(hall_meta))
    else $error("hall synchroniser skipped a stage");
  a_reverse_sense: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R16
    hall_load && hall_cfg.reverse |=> phase_pos[23:18] == $past(6'h00 - sector + hall_cfg.offset))
    else $error("reversed hall sense wrong");
  a_mode_skip: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R14
    ref_state == cpr_pkg::REF_WAIT && !hall_cfg.hall_mode && !wr_phase && !upd |=> phase_pos == $past(phase_pos))
    else $error("reference loaded with hall mode off");
  a_hall_fault_wait: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R17
    ref_state == cpr_pkg::REF_WAIT && hall_fault && hall_cfg.hall_mode |=> ref_state == cpr_pkg::REF_WAIT)
    else $error("invalid hall state ended the reference");
  a_phase_update: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R3
    upd && !hall_load && !wr_phase |=> phase_pos == $past(phase_pos + PHASE_DELTA_I))
    else $error("phase position step wrong");
  a_drive_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R13
    !upd |=> $stable(DRIVE_O))
    else $error("drive changed between phase updates");
  a_read_data: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R3
    AVS_READ_I && !ack |=> AVS_READDATA_O == $past(rd_mux))
    else $error("read data not loaded");
  a_inpos_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R6
    !IN_POSITION_O |-> $past(err_mag >= inpos_band))
    else $error("in-position flag missing with small error");
  // ==========================================
  // covers
  c_hall_load: cover property (@(posedge CLK_I) disable iff (!NRST_I) hall_load);
  c_induction: cover property (@(posedge CLK_I) disable iff (!NRST_I) upd && induction && slip_gain != 24'h000000);
  c_phase_write: cover property (@(posedge CLK_I) disable iff (!NRST_I) wr_phase && in_pos);
  c_power_on: cover property (@(posedge CLK_I) disable iff (!NRST_I) motor_reset_cmd && !power_on_en);
  c_reverse_load: cover property (@(posedge CLK_I) disable iff (!NRST_I) hall_load && hall_cfg.reverse);
endmodule : cpr_top

// *** tb/commutation_phase_reference_tb.sv ***
// self-checking bench of the commutation phase reference block
`timescale 1ns/100ps
module commutation_phase_reference_tb;
  localparam int DIV = 16;
  localparam logic [2:0] HS [6] = '{cpr_pkg::HALL_S0, cpr_pkg::HALL_S1, cpr_pkg::HALL_S2,
    cpr_pkg::HALL_S3, cpr_pkg::HALL_S4, cpr_pkg::HALL_S5};
  localparam logic [5:0] SA [6] = '{cpr_pkg::SECT_A0, cpr_pkg::SECT_A1, cpr_pkg::SECT_A2,
    cpr_pkg::SECT_A3, cpr_pkg::SECT_A4, cpr_pkg::SECT_A5};
  logic clk, nrst, rd, wr, wreq, upd, inpos, rev;
  logic [5:0] adr, off;
  logic [31:0] wdat, rdat, q, d, p, m;
  logic [23:0] flag;
  logic [2:0] hall;
  logic [15:0] gap, updn;
  logic signed [15:0] vel, iq, g;
  logic signed [23:0] fe, pd, e, b;
  logic signed [31:0] pr;
  cpr_pkg::cpr_drive_t drv, seen, prev;
  logic [31:0] seed = 32'h0000001D;
  int error_cnt = 0;
  int compares = 0;
  int n, h;
  // ==========================================
  // design and far side
  cpr_top #(.UPDATE_DIV_P(DIV)) DUT (.CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
    .FLAG_WORD_I(flag), .STRAP_DIV_I(2'h1), .FOLLOW_ERR_I(fe), .VELOCITY_I(vel), .IQ_CMD_I(iq),
    .PHASE_DELTA_I(pd), .DRIVE_O(drv), .PHASE_UPDATE_O(upd), .IN_POSITION_O(inpos));
  cpr_far_model far (.clk_i(clk), .hall_i(hall), .drive_i(drv), .update_i(upd), .flag_o(flag),
    .seen_o(seen), .prev_o(prev), .gap_o(gap), .upd_n_o(updn));
  // ==========================================
  // helpers
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [23:0] hall_exp(input int k, input logic r, input logic [5:0] o);
    logic [5:0] s;
    s = r ? 6'h00 - SA[k] : SA[k];
    return {s + o, 18'h00000};
  endfunction : hall_exp
  task report_and_stop();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task bus(input logic w, input logic [5:0] a, input logic [31:0] dat);
    int k;
    k = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= dat;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
      report_and_stop();
    end
    @(posedge clk);
  endtask : bus
  task rchk(input string nm, input logic [5:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    chk(nm, ex, q);
  endtask : rchk
  task wait_upd(input int k);
    int c;
    logic [15:0] t;
    c = 0;
    t = updn + 16'(k);
    while (updn !== t && c < 400) begin
      @(posedge clk);
      c++;
    end
    if (c >= 400) begin
      error_cnt++;
      report_and_stop();
    end
    @(posedge clk);
  endtask : wait_upd
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
  // ==========================================
  // main sequence
  initial begin
    nrst = 1'b0; rd = 1'b0; wr = 1'b0; adr = 6'h00; wdat = 32'h0; fe = 24'h0;
    vel = 16'h0; iq = 16'h0; pd = 24'h0; hall = 3'h3;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rchk("ctl", cpr_pkg::OFS_CONTROL, 32'h1);
    for (int i = 0; i < 8; i++) if (i != 1) rchk("rst", 6'(i * 4), 32'h0);
    for (int i = 0; i < 8; i++) if (i != 1) begin
      d = rnd();
      bus(1'b1, 6'(i * 4), d);
      rchk("rw", 6'(i * 4), (i == 5 || i == 6) ? d & 32'hFFFF : d & 32'hFFFFFF);
    end
    bus(1'b1, 6'h24, rnd());
    rchk("unmapped", 6'h24, 32'h0);
    for (int i = 0; i < 13; i++) begin
      h = i % 6;
      rev = i > 5;
      off = (i == 0) ? 6'h00 : 6'(rnd());
      hall <= (i == 12) ? 3'h0 : HS[h];
      bus(1'b1, cpr_pkg::OFS_STORED_OFS, rnd());
      bus(1'b1, cpr_pkg::OFS_HALL_CFG, {8'h00, 1'b1, rev, off, 16'(rnd())});
      bus(1'b1, cpr_pkg::OFS_CONTROL, 32'h4 | 32'(i & 1));
      if (i == 12) begin
        bus(1'b0, cpr_pkg::OFS_STATUS, 32'h0);
        chk("hall_wait", 32'hC, q & 32'hE);
        hall <= HS[h];
      end
      n = 0;
      do begin
        bus(1'b0, cpr_pkg::OFS_STATUS, 32'h0);
        n++;
      end while (q[2:1] !== 2'b01 && n < 20);
      rchk("hall_ref", cpr_pkg::OFS_PHASE_POS, hall_exp(h, rev, off));
    end
    bus(1'b1, cpr_pkg::OFS_HALL_CFG, 32'h0);
    bus(1'b1, cpr_pkg::OFS_ADV_GAIN, 32'h0);
    d = rnd();
    pd <= d[23:0];
    wait_upd(3);
    chk("period", DIV * 2, gap);
    chk("delta", d[23:0], 24'(seen.angle - prev.angle));
    pd <= 24'h0;
    for (int j = 0; j < 6; j++) begin
      g = 16'(rnd());
      vel <= (j == 0) ? 16'h8000 : 16'(rnd());
      p = rnd();
      bus(1'b1, cpr_pkg::OFS_HALL_CFG, j[0] ? 32'h800000 : 32'h0);
      bus(1'b1, cpr_pkg::OFS_ADV_GAIN, 32'(g));
      bus(1'b1, cpr_pkg::OFS_PHASE_POS, p);
      wait_upd(2);
      pr = g * vel;
      chk("advance", j[0] ? p[23:0] : 24'(p[23:0] + pr[31:8]), seen.angle);
    end
    bus(1'b1, cpr_pkg::OFS_ADV_GAIN, 32'h0);
    bus(1'b1, cpr_pkg::OFS_HALL_CFG, 32'h0);
    for (int j = 0; j < 4; j++) begin
      m = rnd();
      d = rnd() & 32'h3FF;
      iq <= 16'(rnd());
      bus(1'b1, cpr_pkg::OFS_MAG_CUR, m);
      bus(1'b1, cpr_pkg::OFS_SLIP_GAIN, {8'h00, d[9:0], 14'h0});
      bus(1'b1, cpr_pkg::OFS_CONTROL, 32'h3);
      wait_upd(3);
      pr = $signed(d) * iq;
      chk("id", {16'h0, m[15:0]}, {16'h0, seen.id});
      chk("iq", {16'h0, iq}, {16'h0, seen.iq});
      chk("slip", pr[23:0], 24'(seen.angle - prev.angle));
    end
    bus(1'b1, cpr_pkg::OFS_CONTROL, 32'h1);
    wait_upd(2);
    chk("id_off", 32'h0, {16'h0, seen.id});
    b = 24'(rnd() & 32'hFFF) + 24'h2;
    bus(1'b1, cpr_pkg::OFS_INPOS_BAND, 32'(b));
    for (int j = 0; j < 40; j++) begin
      d = rnd();
      e = (j == 0) ? b : (j == 1) ? -b : (j == 2) ? b - 1 : (j == 3) ? 1 - b : $signed(d[23:0]) >>> 11;
      fe <= e;
      @(posedge clk);
      @(posedge clk);
      chk("inpos", 32'(((e < 0) ? -e : e) < b), 32'(inpos));
    end
    fe <= 24'h0;
    n = 0;
    while (inpos !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    bus(1'b0, cpr_pkg::OFS_STORED_OFS, 32'h0);
    d = q;
    bus(1'b1, cpr_pkg::OFS_PHASE_POS, d);
    rchk("copy", cpr_pkg::OFS_PHASE_POS, d & 32'hFFFFFF);
    report_and_stop();
  end
endmodule : commutation_phase_reference_tb

// *** tb/cpr_far_model.sv ***
// far-side model: hall sensors on the flag word and an amplifier latching the drive
`timescale 1ns/100ps
module cpr_far_model (
  // clock and hall state
  input wire logic clk_i,
  input wire logic [2:0] hall_i,
  // amplifier side
  input wire cpr_pkg::cpr_drive_t drive_i,
  input wire logic update_i,
  output logic [23:0] flag_o,
  output cpr_pkg::cpr_drive_t seen_o,
  output cpr_pkg::cpr_drive_t prev_o,
  output logic [15:0] gap_o,
  output logic [15:0] upd_n_o
);
  // ==========================================
  // sensors: unused flag bits carry a count that steps every cycle, bit 23 copies its lsb
  logic [19:0] noise = 20'h00000;
  logic [15:0] since = 16'h0000;
  logic upd_d = 1'b0;
  logic [15:0] upd_n = 16'h0000;
  assign upd_n_o = upd_n;
  assign flag_o = {noise[0], hall_i, noise};
  // ==========================================
  // amplifier: period count and drive latch
  always @(posedge clk_i) begin
    noise <= noise + 20'h00001;
    upd_d <= update_i;
    since <= update_i ? 16'h0001 : since + 16'h0001;
    if (update_i) begin
      gap_o <= since;
      upd_n <= upd_n + 16'h0001;
    end
    if (upd_d) begin
      prev_o <= seen_o;
      seen_o <= drive_i;
    end
  end
endmodule : cpr_far_model
